// >>> pkg/stc_defines.svh
// register offsets, field positions and reset values of the timer
`ifndef STC_DEFINES_SVH
`define STC_DEFINES_SVH
`define STC_ADDR_COUNT_LOW   8'h0E
`define STC_ADDR_COUNT_HIGH  8'h0F
`define STC_ADDR_CONTROL     8'h10
`define STC_CTRL_RESET       6'h00
`define STC_BIT_ON           0
`define STC_BIT_CS           1
`define STC_BIT_SYNC_DIS     2
`define STC_BIT_OSC_EN       3
`define STC_PS_LSB           4
`define STC_PS_MSB           5
`define STC_CMP_SPECIAL      4'hB
`define STC_PHASE_Q2         2'h1
`define STC_PHASE_Q4         2'h3
`define STC_PSC_RESET        3'h0
`endif

// >>> pkg/stc_pkg.sv
// types shared by the sixteen bit timer/counter
package stc_pkg;
    // special function register access from the cpu
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } stc_sfr_req_t;

    // compare unit view: mode field and match strobe
    typedef struct packed {
        logic [3:0] mode;
        logic       match;
    } stc_cmp_t;

    // whole state of the timer
    typedef struct packed {
        logic [5:0]  ctrl;
        logic [15:0] count;
        logic [2:0]  presc;
        logic [1:0]  phase;
        logic        ext_s1;
        logic        ext_s2;
        logic        osc_s1;
        logic        osc_s2;
        logic        src_prev;
        logic        pre_prev;
        logic        samp;
        logic        samp_prev;
        logic [7:0]  rdata;
        logic        ovf;
        logic        wake;
    } stc_state_t;
endpackage

// >>> design/stc_timer.sv
// sixteen bit timer/counter with three bit prescaler and special event reset
`timescale 1ns/1ps
`include "stc_defines.svh"

module stc_timer (
    // clock and power-on/brown-out reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // cpu register port
    input  wire stc_pkg::stc_sfr_req_t sfr_req,
    output logic [7:0]                sfr_rdata,
    // cpu state
    input  wire logic                 sleep,
    // compare units
    input  wire stc_pkg::stc_cmp_t    compare_unit_a,
    input  wire stc_pkg::stc_cmp_t    compare_unit_b,
    // pins
    input  wire logic                 ext_clock_pin,
    input  wire logic                 osc_in_pin,
    output logic                      osc_amp_enable,
    // events and status
    output logic                      overflow_flag,
    output logic                      wake_request,
    output logic                      timebase_valid,
    output logic [15:0]               count_value
);
    // operating summary
    // one clk period is one phase; four phases make one instruction cycle.
    // phase counter runs free from reset, so phase 3 marks the instruction
    // clock edge used in timer mode.
    // timer mode: count source is the instruction clock; the sync bit is
    // ignored because that source is already in step with clk.
    // sync counter mode: the pin passes two flops, then the prescaler, and
    // its output is sampled on phases 1 and 3 before the count moves.
    // async counter mode: the count follows the prescaler output edge
    // directly, keeps running in sleep and may request a wake-up.
    // limitation: the prescaler here is a clocked divider fed by the
    // synchronised pin, not a true ripple counter; pins faster than about
    // a half of clk are lost in every mode.
    // trade-off: the special event is still applied in async mode, which
    // is allowed since its effect there is left open.
    // priority of count updates: cpu write, then special event, then an
    // increment; a write also clears the prescaler.
    // the count is never reset, so it reads unknown until software or a
    // special event sets it.
    // read data is captured on the read strobe and held, so a byte taken
    // by the cpu can never mix two count values.

    // whole state and its next value
    stc_pkg::stc_state_t r;
    stc_pkg::stc_state_t next_r;

    // special event decode, used for both compare units
    function automatic logic special_event(input stc_pkg::stc_cmp_t c);
        special_event = c.match && (c.mode == `STC_CMP_SPECIAL);
    endfunction

    // register address match for the write decode; read decode uses a case
    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] want);
        addr_hit = (a == want);
    endfunction

    logic       on_bit;
    logic       cs_bit;
    logic       async_mode;
    logic [1:0] ps_sel;
    logic       src_level;
    logic       src_rise;
    logic       pre_level;
    logic       tick;
    logic       trig;
    logic       wr_low;
    logic       wr_high;
    logic       wr_ctrl;
    logic       cnt_wr;
    logic       at_top;

    // control field decode
    assign on_bit     = r.ctrl[`STC_BIT_ON];
    assign cs_bit     = r.ctrl[`STC_BIT_CS];
    assign async_mode = cs_bit && r.ctrl[`STC_BIT_SYNC_DIS];
    assign ps_sel     = r.ctrl[`STC_PS_MSB:`STC_PS_LSB];
    // register write decode; unmapped addresses fall through unused
    assign wr_low     = sfr_req.wr
                        && addr_hit(sfr_req.addr, `STC_ADDR_COUNT_LOW);
    assign wr_high    = sfr_req.wr
                        && addr_hit(sfr_req.addr, `STC_ADDR_COUNT_HIGH);
    assign wr_ctrl    = sfr_req.wr
                        && addr_hit(sfr_req.addr, `STC_ADDR_CONTROL);
    // any count byte write; it also clears the prescaler
    assign cnt_wr     = wr_low || wr_high;
    // last value before the wrap to zero
    assign at_top     = (r.count == 16'hFFFF);
    // either compare unit may reset the count
    assign trig = special_event(compare_unit_a)
                  || special_event(compare_unit_b);

    // count source: instruction clock or a synchronised pin
    // the oscillator pin wins over the external pin when the crystal is
    // enabled, since both pins cannot clock the counter at once
    always_comb begin
        if (!cs_bit) begin
            src_level = (r.phase == `STC_PHASE_Q4);
        end else if (r.ctrl[`STC_BIT_OSC_EN]) begin
            src_level = r.osc_s2;
        end else begin
            src_level = r.ext_s2;
        end
    end
    assign src_rise = src_level && !r.src_prev;

    // prescaler output level; for ps_sel 1 to 3 a divider bit keeps it symmetrical
    // a level, not a pulse, is handed on, so the phase sampler below
    // never misses a short prescaler output while ps_sel is 1 to 3
    always_comb begin
        unique case (ps_sel)
            2'h0: pre_level = src_level;
            2'h1: pre_level = r.presc[0];
            2'h2: pre_level = r.presc[1];
            2'h3: pre_level = r.presc[2];
        endcase
    end

    // increment decision per mode
    // each mode looks for one rising edge of its own source so that a
    // level held across several clocks counts only once
    always_comb begin
        if (!on_bit) begin
            tick = 1'b0;
        end else if (!cs_bit) begin
            // instruction clock stops in sleep
            tick = pre_level && !r.pre_prev && !sleep;
        end else if (async_mode) begin
            tick = pre_level && !r.pre_prev;
        end else begin
            // sync counter holds in sleep; its synchroniser and sampler keep running
            tick = r.samp && !r.samp_prev && !sleep;
        end
    end

    // next state
    // pulses default low each cycle; phase, pin flops and edge history move
    // every cycle; everything else holds unless a branch below moves it
    always_comb begin
        next_r           = r;
        next_r.phase     = r.phase + 2'h1;
        // pin synchronisers; only the second stage feeds logic
        next_r.ext_s1    = ext_clock_pin;
        next_r.ext_s2    = r.ext_s1;
        next_r.osc_s1    = osc_in_pin;
        next_r.osc_s2    = r.osc_s1;
        next_r.src_prev  = src_level;
        next_r.pre_prev  = pre_level;
        next_r.samp_prev = r.samp;
        next_r.ovf       = 1'b0;
        next_r.wake      = 1'b0;
        // sample prescaler output on Q2 and Q4, also during sleep
        if (r.phase == `STC_PHASE_Q2 || r.phase == `STC_PHASE_Q4) begin
            next_r.samp = pre_level;
        end
        // prescaler keeps counting source edges even in sleep
        if (on_bit && src_rise) begin
            next_r.presc = r.presc + 3'h1;
        end
        // count: write beats trigger, trigger beats increment
        // a write on the same cycle as a trigger keeps the written value
        if (cnt_wr) begin
            if (wr_low) begin
                next_r.count[7:0] = sfr_req.wdata;
            end
            if (wr_high) begin
                next_r.count[15:8] = sfr_req.wdata;
            end
            next_r.presc = `STC_PSC_RESET;
        end else if (trig) begin
            // restart at zero, no overflow raised
            next_r.count = 16'h0000;
        end else if (tick) begin
            next_r.count = r.count + 16'h0001;
            // wrap from all ones to zero raises one overflow pulse
            if (at_top) begin
                next_r.ovf  = 1'b1;
                next_r.wake = sleep && async_mode;
            end
        end
        // control register write
        // top two bits are not stored and read back as zero
        if (wr_ctrl) begin
            next_r.ctrl = sfr_req.wdata[5:0];
        end
        // registered read data so a byte never tears
        unique case (sfr_req.addr)
            `STC_ADDR_COUNT_LOW:  next_r.rdata = r.count[7:0];
            `STC_ADDR_COUNT_HIGH: next_r.rdata = r.count[15:8];
            `STC_ADDR_CONTROL:    next_r.rdata = {2'h0, r.ctrl};
            default:              next_r.rdata = 8'h00;
        endcase
        if (!sfr_req.rd) begin
            next_r.rdata = r.rdata;
        end
    end

    // state register; reset leaves the count alone
    // pin synchroniser flops are left to settle on their own, as they
    // only follow the pins and feed edge detectors cleared here
    // the count keeps its value so a reset mid-run does not lose it
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r           <= next_r;
            r.ctrl      <= `STC_CTRL_RESET;
            r.count     <= r.count;
            r.presc     <= `STC_PSC_RESET;
            r.phase     <= 2'h0;
            r.src_prev  <= 1'b0;
            r.pre_prev  <= 1'b0;
            r.samp      <= 1'b0;
            r.samp_prev <= 1'b0;
            r.rdata     <= 8'h00;
            r.ovf       <= 1'b0;
            r.wake      <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // outputs, all from flops except the time base flag
    // time base flag decodes stored control bits only, so it is glitch
    // free for the compare and capture units that read it
    assign sfr_rdata      = r.rdata;
    assign osc_amp_enable = r.ctrl[`STC_BIT_OSC_EN];
    assign overflow_flag  = r.ovf;
    assign wake_request   = r.wake;
    assign timebase_valid = !async_mode;
    assign count_value    = r.count;
endmodule

// >>> verification/stc_clk_src.sv
// external clock or crystal source on one pin
`timescale 1ns/1ps
module stc_clk_src #(
    parameter int HALF_NS = 70
) (
    // gate and pin
    input  wire logic run,
    output logic      pin
);
    // stops low, so a halted source leaves no stray edge
    initial pin = 1'b0;
    always begin
        #(HALF_NS);
        pin = run ? ~pin : 1'b0;
    end
endmodule

// >>> verification/stc_timer_sva.sv
// assertions on the timer ports
`timescale 1ns/1ps
module stc_timer_sva (
    // clock, reset, register port
    input wire logic                  clk,
    input wire logic                  nrst,
    input wire stc_pkg::stc_sfr_req_t sfr_req,
    input wire logic [7:0]            sfr_rdata,
    // compare units and timer outputs
    input wire stc_pkg::stc_cmp_t     compare_unit_a,
    input wire stc_pkg::stc_cmp_t     compare_unit_b,
    input wire logic                  overflow_flag,
    input wire logic [15:0]           count_value
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // mode 1011 plus match packs to 17h
    wire logic sev = compare_unit_a == 5'h17 || compare_unit_b == 5'h17;
    wire logic wctl = sfr_req.wr && sfr_req.addr == 8'h10;
    chk_sev_clear: assert property (sev && !sfr_req.wr |=>
        count_value == 16'h0000) else $error("no event clear");
    chk_sev_no_ovf: assert property (sev && |count_value |=>
        !overflow_flag [*2]) else $error("overflow on event");
    chk_ovf_cause: assert property ($rose(overflow_flag) |->
        $past(count_value) == 16'hFFFF || $past(count_value, 2) == 16'hFFFF)
        else $error("overflow without wrap");
    chk_rd_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
        else $error("read data moved");
    chk_top_bits: assert property (
        sfr_req.rd && sfr_req.addr == 8'h10 |=> sfr_rdata[7:6] == 2'b00)
        else $error("control top bits set");
    chk_high_wr: assert property (
        sfr_req.wr && sfr_req.addr == 8'h0F |=>
        count_value[15:8] == $past(sfr_req.wdata)) else $error("high lost");
    chk_low_wr: assert property (
        sfr_req.wr && sfr_req.addr == 8'h0E |=>
        count_value[7:0] == $past(sfr_req.wdata)) else $error("low lost");
    chk_off_hold: assert property (
        wctl && !sfr_req.wdata[0] ##1 (!sfr_req.wr && !sev) [*8] |->
        $stable(count_value)) else $error("count moved while off");
endmodule
bind stc_timer stc_timer_sva i_stc_timer_sva (.clk, .nrst, .sfr_req,
    .sfr_rdata, .compare_unit_a, .compare_unit_b, .overflow_flag,
    .count_value);

// >>> verification/stc_timer_bench.sv
// self-checking bench for the timer/counter
`timescale 1ns/1ps
module stc_timer_bench;
    logic                  clk, nrst, sleep, ext, osc, amp, ovf, tbv, wk;
    logic                  run_e, run_o;
    logic [7:0]            rdata;
    logic [15:0]           cnt, c0;
    stc_pkg::stc_sfr_req_t rq;
    stc_pkg::stc_cmp_t     ca, cb;
    int                    err_total, samples_checked, n_ovf, n_pin, n_wake;
    stc_timer i_stc_timer (.clk(clk), .nrst(nrst), .sfr_req(rq),
        .sfr_rdata(rdata), .sleep(sleep), .compare_unit_a(ca),
        .compare_unit_b(cb), .ext_clock_pin(ext), .osc_in_pin(osc),
        .osc_amp_enable(amp), .overflow_flag(ovf), .wake_request(wk),
        .timebase_valid(tbv), .count_value(cnt));
    stc_clk_src #(.HALF_NS(70)) i_stc_clk_src (.run(run_e), .pin(ext));
    stc_clk_src #(.HALF_NS(110)) i_stc_clk_src_osc (.run(run_o), .pin(osc));
    // clock and event tallies
    always #10 clk = ~clk;
    always @(posedge clk) n_ovf += (ovf === 1'b1);
    always @(posedge clk) n_wake += (wk === 1'b1);
    always @(posedge ext or posedge osc) n_pin++;
    task automatic chk(logic [15:0] s, logic [15:0] e);
        samples_checked++;
        if (s !== e) err_total++;
        if (s !== e) $display("wrong value at %0t: %h not %h", $time, s, e);
    endtask
    task automatic idle(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk) rq <= '{1'b1, 1'b0, a, d};
        @(posedge clk) rq <= '0;
    endtask
    // read data is registered, so look one cycle on
    task automatic rd(logic [7:0] a, logic [15:0] e);
        @(posedge clk) rq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) rq <= '0;
        @(negedge clk) chk(rdata, e);
    endtask
    task automatic t_regs;
        rd(8'h10, 16'h0000);
        rd(8'h20, 16'h0000);
        wr(8'h0F, 8'h00);
        wr(8'h0E, 8'h00);
        wr(8'h10, 8'hFF);
        rd(8'h10, 16'h003F);
        chk(amp, 16'h0001);
        chk(tbv, 16'h0000);
    endtask
    task automatic t_presc;
        for (int p = 0; p < 4; p++) begin
            wr(8'h10, {2'b00, p[1:0], 4'h5});
            idle(64);
            c0 = cnt;
            idle(32 << p);
            chk(cnt - c0, 16'h0008);
        end
        wr(8'h10, 8'h00);
        idle(4);
        c0 = cnt;
        idle(40);
        chk(cnt, c0);
    endtask
    task automatic t_event;
        wr(8'h0F, 8'hFF);
        wr(8'h0E, 8'hFC);
        wr(8'h10, 8'h01);
        idle(24);
        chk(n_ovf, 16'h0001);
        wr(8'h10, 8'h31);
        wr(8'h0F, 8'hFF);
        wr(8'h0E, 8'hFF);
        @(posedge clk) ca <= 5'h17;
        @(posedge clk) ca <= 5'h16;
        @(negedge clk) chk(cnt, 16'h0000);
        idle(8);
        chk(n_ovf, 16'h0001);
        @(posedge clk) rq <= '{1'b1, 1'b0, 8'h0F, 8'h34};
        cb <= 5'h17;
        @(posedge clk) rq <= '0;
        cb <= 5'h15;
        @(posedge clk) cb <= 5'h14;
        @(negedge clk) chk(cnt[15:8], 16'h0034);
        wr(8'h10, 8'h00);
        wr(8'h0E, 8'h56);
        rd(8'h0F, 16'h0034);
        rd(8'h0E, 16'h0056);
        rd(8'h0F, 16'h0034);
    endtask
    task automatic t_pins;
        logic [7:0] m [4] = '{8'h03, 8'h0B, 8'h03, 8'h07};
        for (int i = 0; i < 4; i++) begin
            wr(8'h10, m[i]);
            sleep <= (i > 1);
            idle(4);
            c0 = cnt;
            n_pin = 0;
            {run_o, run_e} = m[i][3] ? 2'b10 : 2'b01;
            idle(100);
            {run_o, run_e} = 2'b00;
            idle(20);
            chk(cnt - c0, (i == 2) ? 16'h0000 : 16'(n_pin));
            chk(tbv, {15'h0000, i < 3});
        end
        // async overflow during sleep must raise one wake pulse
        wr(8'h10, 8'h06);
        wr(8'h0F, 8'hFF);
        wr(8'h0E, 8'hFF);
        wr(8'h10, 8'h07);
        n_wake = 0;
        run_e = 1'b1;
        idle(20);
        run_e = 1'b0;
        idle(20);
        chk(16'(n_wake), 16'h0001);
        sleep <= 1'b0;
    endtask
    task automatic results;
        $display("checks %0d, errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        {clk, nrst, sleep, run_e, run_o, rq, ca, cb} = '0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_presc();
        t_event();
        t_pins();
        results();
    end
    // a hang costs one error
    initial begin
        #1000000;
        err_total++;
        results();
    end
endmodule
